// ### eeseq_core.sv
// Enclave entry sequencer: checks, page walk and state switch
`timescale 1ns/10ps
`default_nettype none
module eeseq_core
  import eeseq_pkg::*;
#(
  parameter int FRAME_W = 32
) (
  input  wire logic          core_clk_in,
  input  wire logic          rst_b_in,
  input  wire logic          start_in,
  input  wire logic          wide_mode_in,
  input  wire logic [63:0]   cs_base_in,
  input  wire logic [63:0]   cs_limit_in,
  input  wire logic [63:0]   ds_base_in,
  input  wire logic [63:0]   ds_limit_in,
  input  wire logic          ds_w_in,
  input  wire logic [1:0]    ds_dpl_in,
  input  wire logic          ds_avl_in,
  input  wire logic          ds_l_in,
  input  wire logic          es_usable_in,
  input  wire logic [63:0]   es_base_in,
  input  wire logic          ss_usable_in,
  input  wire logic [63:0]   ss_base_in,
  input  wire logic          ss_b_in,
  input  wire logic [63:0]   thread_addr_in,
  input  wire logic [63:0]   exit_ptr_in,
  input  wire logic [63:0]   next_ip_in,
  input  wire logic          thread_busy_in,
  input  wire logic          thread_active_in,
  input  wire logic [63:0]   save_area_offset_in,
  input  wire logic [63:0]   fs_base_offset_in,
  input  wire logic [63:0]   gs_base_offset_in,
  input  wire logic [31:0]   fs_limit_in,
  input  wire logic [31:0]   gs_limit_in,
  input  wire logic [63:0]   entry_offset_in,
  input  wire logic [63:0]   flow_guard_save_offset_in,
  input  wire logic [63:0]   thread_flags_in,
  input  wire logic          debug_opt_in_in,
  input  wire logic [FRAME_W-1:0] current_frame_index_in,
  input  wire logic [FRAME_W-1:0] frame_count_in,
  input  wire logic [63:0]   enclave_base_in,
  input  wire logic [63:0]   enclave_size_in,
  input  wire logic [31:0]   frame_pages_in,
  input  wire logic [63:0]   xsave_size_in,
  input  wire logic [63:0]   gpr_size_in,
  input  wire logic          enclave_init_in,
  input  wire logic          wide_mode_attribute_in,
  input  wire logic [63:0]   enclave_feature_mask_in,
  input  wire logic          flow_feature_in,
  input  wire logic          os_flow_guard_enable_in,
  input  wire logic          flow_attr_nonzero_in,
  input  wire logic          shadow_stack_enable_in,
  input  wire logic          branch_tracking_enable_in,
  input  wire logic          os_fx_state_enable_in,
  input  wire logic          os_extended_state_enable_in,
  input  wire logic [63:0]   xcr0_in,
  input  wire logic          tf_in,
  input  wire logic          mtf_ctrl_in,
  input  wire logic [15:0]   fs_sel_in,
  input  wire logic [63:0]   fs_base_in,
  input  wire logic [31:0]   fs_lim_in,
  input  wire logic [11:0]   fs_ar_in,
  input  wire logic [15:0]   gs_sel_in,
  input  wire logic [63:0]   gs_base_in,
  input  wire logic [31:0]   gs_lim_in,
  input  wire logic [11:0]   gs_ar_in,
  output logic [63:0]        map_addr_out,
  output logic               map_req_out,
  input  wire logic          map_ack_in,
  input  wire logic          map_in_cache_in,
  input  wire logic          map_valid_in,
  input  wire logic          map_blocked_in,
  input  wire logic          map_pending_in,
  input  wire logic          map_modified_in,
  input  wire logic          map_read_in,
  input  wire logic          map_write_in,
  input  wire logic [2:0]    map_type_in,
  input  wire logic [63:0]   map_lin_addr_in,
  input  wire logic [63:0]   map_owner_in,
  input  wire logic [63:0]   map_phys_in,
  output logic               busy_out,
  output logic               done_out,
  output logic [1:0]         fault_out,
  output logic [63:0]        fault_addr_out,
  output logic               lock_out,
  output logic               enclave_mode_out,
  output logic [63:0]        range_base_out,
  output logic [63:0]        range_size_out,
  output logic [63:0]        thread_pa_out,
  output logic [63:0]        thread_la_out,
  output logic [63:0]        exit_ptr_out,
  output logic [63:0]        gpr_pa_out,
  output logic [63:0]        flow_pa_out,
  output logic [63:0]        xsave_pa_out,
  output logic [63:0]        rcx_out,
  output logic [63:0]        rip_out,
  output logic [63:0]        rax_out,
  output logic [63:0]        rsp_save_addr_out,
  output logic [63:0]        xcr0_out,
  output logic [63:0]        save_xcr0_out,
  output logic [15:0]        save_fs_sel_out,
  output logic [63:0]        save_fs_base_out,
  output logic [31:0]        save_fs_lim_out,
  output logic [11:0]        save_fs_ar_out,
  output logic [15:0]        save_gs_sel_out,
  output logic [63:0]        save_gs_base_out,
  output logic [31:0]        save_gs_lim_out,
  output logic [11:0]        save_gs_ar_out,
  output logic [63:0]        fs_base_out,
  output logic [31:0]        fs_lim_out,
  output logic [15:0]        seg_sel_out,
  output logic [13:0]        seg_ar_out,
  output logic [63:0]        gs_base_out,
  output logic [31:0]        gs_lim_out,
  output logic               tf_out,
  output logic               saved_tf_out,
  output logic               debug_suppress_out,
  output logic               pend_step_out,
  output logic               pend_mtf_out
);
  // ==========================================================
  // Helpers
  function automatic logic canon(input logic [63:0] a);
    canon = (a[63:EESEQ_VA_BITS-1] == '0) || (a[63:EESEQ_VA_BITS-1] == '1);
  endfunction
  function automatic logic page_ok(input logic [2:0] pt, input logic [63:0] la,
                                   input logic rw, input logic same);
    page_ok = map_in_cache_in && map_valid_in && !map_blocked_in && !map_pending_in
            && !map_modified_in && (map_type_in == pt) && (map_lin_addr_in == la)
            && (!rw || (map_read_in && map_write_in)) && same;
  endfunction

  // ==========================================================
  // Combinational checks
  logic [63:0] fsb, gsb, fsl, gsl, state_save_frame, gpr, tgt, flow, ssa_end;
  logic        gp_chk;
  always_comb begin
    fsb = fs_base_offset_in + enclave_base_in;
    gsb = gs_base_offset_in + enclave_base_in;
    fsl = fsb + {32'h0, fs_limit_in};
    gsl = gsb + {32'h0, gs_limit_in};
    state_save_frame = save_area_offset_in + enclave_base_in + EESEQ_PAGE_BYTES
        * {32'h0, frame_pages_in} * 64'(current_frame_index_in);
    gpr = state_save_frame + EESEQ_PAGE_BYTES * {32'h0, frame_pages_in} - gpr_size_in;
    ssa_end = state_save_frame + xsave_size_in;
    tgt = entry_offset_in + enclave_base_in;
    flow = flow_guard_save_offset_in + enclave_base_in
         + EESEQ_FLOW_STRIDE * 64'(current_frame_index_in);
    gp_chk = 1'b0;
    if (!wide_mode_in) begin
      if (cs_base_in != '0 || ds_base_in != '0 || (es_usable_in && es_base_in != '0)
          || (ss_usable_in && (ss_base_in != '0 || !ss_b_in)))
        gp_chk = 1'b1;
      if ((fsl < fsb) ? (ds_limit_in < EESEQ_LIMIT_4G) : (fsl > ds_limit_in))
        gp_chk = 1'b1;
      if ((gsl < gsb) ? (ds_limit_in < EESEQ_LIMIT_4G) : (gsl > ds_limit_in))
        gp_chk = 1'b1;
      if (gpr + gpr_size_in - 64'h1 > ds_limit_in)
        gp_chk = 1'b1;
      if (tgt > cs_limit_in)
        gp_chk = 1'b1;
    end else begin
      if (!canon(exit_ptr_in))
        gp_chk = 1'b1;
      if (!canon(fsb) || !canon(gsb))
        gp_chk = 1'b1;
      if (!canon(tgt))
        gp_chk = 1'b1;
    end
    if (thread_addr_in[11:0] != '0 || save_area_offset_in[11:0] != '0
        || fs_base_offset_in[11:0] != '0 || gs_base_offset_in[11:0] != '0)
      gp_chk = 1'b1;
    if (thread_busy_in || thread_active_in)
      gp_chk = 1'b1;
    if ((thread_flags_in & EESEQ_FLAGS_RSVD) != '0)
      gp_chk = 1'b1;
    if (!enclave_init_in || wide_mode_in != wide_mode_attribute_in)
      gp_chk = 1'b1;
    if (!os_fx_state_enable_in)
      gp_chk = 1'b1;
    if (!os_extended_state_enable_in ? (enclave_feature_mask_in != EESEQ_ENCLAVE_FEATURE_MASK_LEGACY)
        : ((enclave_feature_mask_in & xcr0_in) != enclave_feature_mask_in))
      gp_chk = 1'b1;
    if (current_frame_index_in >= frame_count_in)
      gp_chk = 1'b1;
    if (flow_feature_in && ((!os_flow_guard_enable_in && flow_attr_nonzero_in)
        || ((shadow_stack_enable_in || branch_tracking_enable_in)
            && (flow_guard_save_offset_in[3:0] & EESEQ_ALIGN16) != '0)))
      gp_chk = 1'b1;
  end

  // ==========================================================
  // Sequencer
  eeseq_state_t state, next_state;
  logic [63:0]  page, next_page, owner, next_owner;
  logic [63:0]  fa, next_fa;
  eeseq_fault_t ft, next_ft;
  logic         flow_need;
  logic         pg_ok;
  assign flow_need = flow_feature_in && (shadow_stack_enable_in || branch_tracking_enable_in);
  always_comb begin
    next_state = state;
    next_page  = page;
    next_owner = owner;
    next_fa    = fa;
    next_ft    = ft;
    pg_ok      = 1'b0;
    unique case (state)
      EESEQ_IDLE: begin
        next_ft = EESEQ_F_NONE;
        if (start_in) begin
          next_state = EESEQ_CHECK;
        end
      end
      EESEQ_CHECK: begin
        next_page = thread_addr_in;
        if (gp_chk) begin
          next_ft = EESEQ_F_GP;
          next_fa = '0;
          next_state = EESEQ_FAULT;
        end else begin
          next_state = EESEQ_TPAGE;
        end
      end
      EESEQ_TPAGE: begin
        if (map_ack_in) begin
          pg_ok = page_ok(EESEQ_PT_THREAD, page, 1'b0, 1'b1);
          next_owner = map_owner_in;
          next_page = {state_save_frame[63:12], 12'h0};
          next_state = pg_ok ? EESEQ_SSA : EESEQ_FAULT;
        end
      end
      EESEQ_SSA: begin
        if (map_ack_in) begin
          pg_ok = page_ok(EESEQ_PT_REGULAR, page, 1'b1, map_owner_in == owner);
          next_page = page + EESEQ_PAGE_BYTES;
          if (!pg_ok) begin
            next_state = EESEQ_FAULT;
          end else if (page + EESEQ_PAGE_BYTES >= ssa_end) begin
            next_page = {gpr[63:12], 12'h0};
            next_state = EESEQ_GPR;
          end
        end
      end
      EESEQ_GPR: begin
        if (map_ack_in) begin
          pg_ok = page_ok(EESEQ_PT_REGULAR, {page[63:12], 12'h0}, 1'b1,
                          map_owner_in == owner);
          next_page = {flow[63:12], 12'h0};
          next_state = !pg_ok ? EESEQ_FAULT : flow_need ? EESEQ_FLOW : EESEQ_COMMIT;
        end
      end
      EESEQ_FLOW: begin
        if (map_ack_in) begin
          pg_ok = page_ok(EESEQ_PT_SHADOW, page, 1'b1, map_owner_in == owner);
          next_state = pg_ok ? EESEQ_COMMIT : EESEQ_FAULT;
        end
      end
      EESEQ_COMMIT: next_state = EESEQ_IDLE;
      EESEQ_FAULT: next_state = EESEQ_IDLE;
    endcase
    if (state inside {EESEQ_TPAGE, EESEQ_SSA, EESEQ_GPR, EESEQ_FLOW}
        && map_ack_in && !pg_ok) begin
      next_ft = EESEQ_F_PF;
      next_fa = page;
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= EESEQ_IDLE;
      page  <= '0;
      owner <= '0;
      fa    <= '0;
      ft    <= EESEQ_F_NONE;
    end else begin
      state <= next_state;
      page  <= next_page;
      owner <= next_owner;
      fa    <= next_fa;
      ft    <= next_ft;
    end
  end

  // ==========================================================
  // Outputs and architectural commit
  logic commit;
  logic walk;
  assign commit = (state == EESEQ_COMMIT);
  assign walk   = state inside {EESEQ_TPAGE, EESEQ_SSA, EESEQ_GPR, EESEQ_FLOW};
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      map_addr_out <= '0;       map_req_out <= 1'b0;
      busy_out <= 1'b0;         done_out <= 1'b0;
      fault_out <= EESEQ_F_NONE; fault_addr_out <= '0;
      lock_out <= 1'b0;         enclave_mode_out <= 1'b0;
      range_base_out <= '0;     range_size_out <= '0;
      thread_pa_out <= '0;      thread_la_out <= '0;
      exit_ptr_out <= '0;       gpr_pa_out <= '0;
      flow_pa_out <= '0;        xsave_pa_out <= '0;
      rcx_out <= '0;            rip_out <= '0;
      rax_out <= '0;            rsp_save_addr_out <= '0;
      xcr0_out <= '0;           save_xcr0_out <= '0;
      save_fs_sel_out <= '0;    save_fs_base_out <= '0;
      save_fs_lim_out <= '0;    save_fs_ar_out <= '0;
      save_gs_sel_out <= '0;    save_gs_base_out <= '0;
      save_gs_lim_out <= '0;    save_gs_ar_out <= '0;
      fs_base_out <= '0;        fs_lim_out <= '0;
      gs_base_out <= '0;        gs_lim_out <= '0;
      seg_sel_out <= '0;        seg_ar_out <= '0;
      tf_out <= 1'b0;           saved_tf_out <= 1'b0;
      debug_suppress_out <= 1'b0;
      pend_step_out <= 1'b0;    pend_mtf_out <= 1'b0;
    end else begin
      map_req_out <= (next_state inside {EESEQ_TPAGE, EESEQ_SSA, EESEQ_GPR, EESEQ_FLOW})
                   && !(walk && map_ack_in && next_state == state && next_page == page);
      map_addr_out <= next_page;
      busy_out <= (next_state != EESEQ_IDLE);
      lock_out <= next_state inside {EESEQ_CHECK, EESEQ_TPAGE, EESEQ_SSA,
                                     EESEQ_GPR, EESEQ_FLOW, EESEQ_COMMIT};
      done_out <= commit || (state == EESEQ_FAULT);
      fault_out <= (state == EESEQ_FAULT) ? ft : EESEQ_F_NONE;
      fault_addr_out <= (state == EESEQ_FAULT) ? fa : '0;
      if (state == EESEQ_SSA && map_ack_in) xsave_pa_out <= map_phys_in;
      if (state == EESEQ_TPAGE && map_ack_in) thread_pa_out <= map_phys_in;
      if (state == EESEQ_GPR && map_ack_in)
        gpr_pa_out <= {map_phys_in[63:12], gpr[11:0]};
      if (state == EESEQ_FLOW && map_ack_in)
        flow_pa_out <= {map_phys_in[63:12], flow[11:0]};
      pend_step_out <= 1'b0;
      pend_mtf_out <= 1'b0;
      if (commit) begin
        enclave_mode_out <= 1'b1;
        range_base_out <= enclave_base_in;
        range_size_out <= enclave_size_in;
        thread_la_out <= thread_addr_in;
        exit_ptr_out <= exit_ptr_in;
        save_fs_sel_out <= fs_sel_in; save_fs_base_out <= fs_base_in;
        save_fs_lim_out <= fs_lim_in; save_fs_ar_out <= fs_ar_in;
        save_gs_sel_out <= gs_sel_in; save_gs_base_out <= gs_base_in;
        save_gs_lim_out <= gs_lim_in; save_gs_ar_out <= gs_ar_in;
        xcr0_out <= xcr0_in;
        if (os_extended_state_enable_in) begin
          save_xcr0_out <= xcr0_in;
          xcr0_out <= enclave_feature_mask_in;
        end
        rcx_out <= next_ip_in;
        rip_out <= tgt;
        rax_out <= 64'(current_frame_index_in);
        rsp_save_addr_out <= gpr;
        fs_base_out <= fsb; fs_lim_out <= fs_limit_in;
        gs_base_out <= gsb; gs_lim_out <= gs_limit_in;
        seg_sel_out <= EESEQ_SEG_SEL;
        // Attribute layout: type,S,DPL,P,AVL,L,B,G,W,unusable
        seg_ar_out <= {EESEQ_SEG_TYPE, 1'b1, ds_dpl_in, 1'b1, ds_avl_in,
                       ds_l_in, 1'b1, 1'b1, ds_w_in, 1'b0};
        if (!debug_opt_in_in) begin
          debug_suppress_out <= 1'b1;
          saved_tf_out <= tf_in;
          tf_out <= 1'b0;
        end else begin
          debug_suppress_out <= 1'b0;
          tf_out <= tf_in;
          pend_step_out <= tf_in;
          pend_mtf_out <= mtf_ctrl_in;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### eeseq_pkg.sv
// Constants and types shared by the enclave entry sequencer
package eeseq_pkg;
  localparam int          EESEQ_AW          = 64;
  localparam int          EESEQ_VA_BITS     = 48;
  localparam logic [11:0] EESEQ_PAGE_MASK   = 12'hfff;
  localparam logic [3:0]  EESEQ_ALIGN16     = 4'hf;
  localparam logic [63:0] EESEQ_PAGE_BYTES  = 64'h0000_0000_0000_1000;
  localparam logic [63:0] EESEQ_LIMIT_4G    = 64'h0000_0000_ffff_ffff;
  localparam logic [63:0] EESEQ_FLAGS_RSVD  = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] EESEQ_ENCLAVE_FEATURE_MASK_LEGACY = 64'h0000_0000_0000_0003;
  localparam logic [3:0]  EESEQ_SEG_TYPE    = 4'h1;
  localparam logic [15:0] EESEQ_SEG_SEL     = 16'h000b;
  localparam logic [63:0] EESEQ_FLOW_STRIDE = 64'h0000_0000_0000_0010;
  localparam logic [2:0]  EESEQ_PT_THREAD   = 3'h1;
  localparam logic [2:0]  EESEQ_PT_REGULAR  = 3'h2;
  localparam logic [2:0]  EESEQ_PT_SHADOW   = 3'h4;
  typedef enum logic [1:0] {EESEQ_F_NONE, EESEQ_F_GP, EESEQ_F_PF} eeseq_fault_t;
  typedef enum {EESEQ_IDLE, EESEQ_CHECK, EESEQ_TPAGE, EESEQ_SSA, EESEQ_GPR,
                EESEQ_FLOW, EESEQ_COMMIT, EESEQ_FAULT} eeseq_state_t;
endpackage

// ### eeseq_core_chk.sv
// Assertion checker for the enclave entry sequencer ports
`timescale 1ns/10ps
`default_nettype none
module eeseq_core_chk
  import eeseq_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        rst_b_in,
  input wire logic        start_in,
  input wire logic        thread_busy_in,
  input wire logic        debug_opt_in_in,
  input wire logic        tf_in,
  input wire logic        mtf_ctrl_in,
  input wire logic [63:0] thread_addr_in,
  input wire logic        map_req_out,
  input wire logic [63:0] map_addr_out,
  input wire logic        busy_out,
  input wire logic        done_out,
  input wire logic [1:0]  fault_out,
  input wire logic        lock_out,
  input wire logic        enclave_mode_out,
  input wire logic [63:0] rcx_out,
  input wire logic [15:0] seg_sel_out,
  input wire logic        tf_out,
  input wire logic        debug_suppress_out,
  input wire logic        pend_step_out,
  input wire logic        pend_mtf_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  // ==========================================
  // Sequences
  sequence s_take;
    start_in && !busy_out;
  endsequence
  sequence s_ok_done;
    done_out && fault_out == EESEQ_F_NONE;
  endsequence
  sequence s_bad_done;
    done_out && fault_out != EESEQ_F_NONE;
  endsequence
  // ==========================================
  // Properties
  gp_early_a: assert property (s_take ##0 thread_busy_in |-> ##3
    (done_out && fault_out == EESEQ_F_GP)) else $error("busy structure not refused in time");
  thread_lookup_a: assert property (s_take ##2 map_req_out |->
    map_addr_out == thread_addr_in) else $error("first lookup not at thread structure");
  entry_bound_a: assert property (s_take |-> ##[1:200] done_out)
    else $error("entry never completed");
  done_pulse_a: assert property (done_out |=> !done_out)
    else $error("done held longer than one cycle");
  lock_drop_a: assert property (done_out |-> !lock_out)
    else $error("lock held after entry ended");
  fault_clean_a: assert property (s_bad_done |-> $stable(enclave_mode_out)
    && $stable(rcx_out) && !pend_step_out) else $error("faulted entry changed state");
  commit_seg_a: assert property (s_ok_done |-> enclave_mode_out
    && seg_sel_out == EESEQ_SEG_SEL) else $error("commit without mode or selector");
  opt_out_a: assert property (s_ok_done ##0 !$past(debug_opt_in_in) |-> !tf_out
    && debug_suppress_out && !pend_step_out && !pend_mtf_out) else $error("opt-out debug");
  step_pend_a: assert property (pend_step_out |-> done_out
    && $past(debug_opt_in_in) && $past(tf_in))
    else $error("step pended without cause");
  mtf_pend_a: assert property (pend_mtf_out |-> done_out && $past(debug_opt_in_in)
    && $past(mtf_ctrl_in)) else $error("trap exit pended without cause");
endmodule
bind eeseq_core eeseq_core_chk i_chk (.*);
`default_nettype wire

// ### tb_eeseq_core.sv
// Self-checking testbench for the enclave entry sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_eeseq_core
  import eeseq_pkg::*;
;
  localparam int FW = 32;
  logic core_clk_in, rst_b_in, start_in, wide_mode_in, ds_w_in, ds_avl_in, ds_l_in, es_usable_in,
    ss_usable_in, ss_b_in, thread_busy_in, thread_active_in, debug_opt_in_in, enclave_init_in,
    wide_mode_attribute_in, flow_feature_in, os_flow_guard_enable_in, flow_attr_nonzero_in,
    shadow_stack_enable_in, branch_tracking_enable_in, os_fx_state_enable_in,
    os_extended_state_enable_in, tf_in, mtf_ctrl_in, map_ack_in, map_in_cache_in, map_valid_in,
    map_blocked_in, map_pending_in, map_modified_in, map_read_in, map_write_in, map_req_out,
    busy_out, done_out, lock_out, enclave_mode_out, tf_out, saved_tf_out, debug_suppress_out,
    pend_step_out, pend_mtf_out, hit;
  logic [1:0] ds_dpl_in, fault_out;
  logic [2:0] map_type_in;
  logic [11:0] fs_ar_in, gs_ar_in, save_fs_ar_out, save_gs_ar_out;
  logic [13:0] seg_ar_out;
  logic [15:0] fs_sel_in, gs_sel_in, save_fs_sel_out, save_gs_sel_out, seg_sel_out;
  logic [31:0] fs_limit_in, gs_limit_in, frame_pages_in, fs_lim_in, gs_lim_in, save_fs_lim_out,
    save_gs_lim_out, fs_lim_out, gs_lim_out;
  logic [FW-1:0] current_frame_index_in, frame_count_in;
  logic [63:0] cs_base_in, cs_limit_in, ds_base_in, ds_limit_in, es_base_in, ss_base_in,
    thread_addr_in, exit_ptr_in, next_ip_in, save_area_offset_in, fs_base_offset_in,
    gs_base_offset_in, entry_offset_in, flow_guard_save_offset_in, thread_flags_in,
    enclave_base_in, enclave_size_in, xsave_size_in, gpr_size_in, enclave_feature_mask_in, xcr0_in,
    fs_base_in, gs_base_in, map_lin_addr_in, map_owner_in, map_phys_in, map_addr_out,
    fault_addr_out, range_base_out, range_size_out, thread_pa_out, thread_la_out, exit_ptr_out,
    gpr_pa_out, flow_pa_out, xsave_pa_out, rcx_out, rip_out, rax_out, rsp_save_addr_out, xcr0_out,
    save_xcr0_out, save_fs_base_out, save_gs_base_out, fs_base_out, gs_base_out, bad_page;
  int bad_kind, failures, check_count;
  logic [1:0] f;
  eeseq_core #(.FRAME_W(FW)) i_dut (.*);
  // ==========================================
  // Clock and protected page map responder
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  assign hit = (map_addr_out == bad_page);
  function automatic logic [63:0] flow_pg();
    return (flow_guard_save_offset_in + enclave_base_in + 64'(current_frame_index_in) * 64'h10)
      & ~64'hfff;
  endfunction
  always @(negedge core_clk_in) begin
    map_ack_in <= map_req_out && !map_ack_in;
    {map_valid_in, map_blocked_in} <= {!(hit && bad_kind == 0), hit && bad_kind == 1};
    {map_pending_in, map_modified_in} <= {hit && bad_kind == 2, hit && bad_kind == 3};
    map_lin_addr_in <= map_addr_out ^ ((hit && bad_kind == 4) ? 64'h1000 : 64'h0);
    map_type_in <= (map_addr_out == thread_addr_in ? EESEQ_PT_THREAD : map_addr_out == flow_pg()
      ? EESEQ_PT_SHADOW : EESEQ_PT_REGULAR) ^ {3{hit && bad_kind == 5}};
    {map_read_in, map_write_in} <= {!(hit && bad_kind == 6), !(hit && bad_kind == 7)};
    map_in_cache_in <= !(hit && bad_kind == 8);
    map_owner_in <= (hit && bad_kind == 9) ? 64'h2000 : 64'h1000;
    map_phys_in <= map_addr_out;
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input string what, input logic [191:0] seen, input logic [191:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic set_base();
    {wide_mode_in, wide_mode_attribute_in, ds_avl_in, ds_l_in, thread_busy_in} = '0;
    {thread_active_in, debug_opt_in_in, flow_feature_in, os_flow_guard_enable_in} = '0;
    {flow_attr_nonzero_in, shadow_stack_enable_in, branch_tracking_enable_in} = '0;
    {os_extended_state_enable_in, mtf_ctrl_in, bad_kind} = '0;
    {ds_w_in, es_usable_in, ss_usable_in, ss_b_in, enclave_init_in, os_fx_state_enable_in} = '1;
    {cs_base_in, ds_base_in, es_base_in, ss_base_in, thread_flags_in} = '0;
    {cs_limit_in, ds_limit_in, bad_page} = {64'hffff_ffff, 64'hffff_ffff, 64'hffff_ffff_ffff_ffff};
    {ds_dpl_in, tf_in} = 3'h7;
    {enclave_base_in, enclave_size_in, thread_addr_in} = {64'h10_0000, 64'h10_0000, 64'h10_1000};
    {exit_ptr_in, next_ip_in, save_area_offset_in} = {64'h4000, 64'h5123, 64'h2000};
    {fs_base_offset_in, gs_base_offset_in, entry_offset_in} = {64'h8000, 64'h9000, 64'h100};
    flow_guard_save_offset_in = 64'h6000;
    {fs_limit_in, gs_limit_in, frame_pages_in} = {32'hfff, 32'hfff, 32'h2};
    {current_frame_index_in, frame_count_in} = {FW'(1), FW'(2)};
    {xsave_size_in, gpr_size_in, enclave_feature_mask_in, xcr0_in} = {64'h1000, 64'hb8, 64'h3, 64'h7};
    {fs_sel_in, gs_sel_in, fs_ar_in, gs_ar_in} = {16'h33, 16'h3b, 12'h0f3, 12'h0f2};
    {fs_base_in, gs_base_in, fs_lim_in, gs_lim_in} = {64'ha000, 64'hb000, 32'h1234, 32'h5678};
  endtask
  task automatic run();
    int n;
    n = 0;
    @(negedge core_clk_in) start_in = 1'b1;
    @(negedge core_clk_in) start_in = 1'b0;
    while (done_out !== 1'b1 && n < 200) begin
      @(negedge core_clk_in);
      n++;
    end
    if (n >= 200) failures++;
    f = fault_out;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_gp_table();
    for (int k = 0; k < 19; k++) begin
      set_base();
      case (k)
        0: cs_base_in = 64'h10;
        1: ss_b_in = 1'b0;
        2: thread_addr_in = 64'h10_1008;
        3: save_area_offset_in = 64'h2010;
        4: {wide_mode_in, wide_mode_attribute_in, exit_ptr_in} = {2'b11, 64'h8000_0000_0000};
        5: thread_busy_in = 1'b1;
        6: thread_active_in = 1'b1;
        7: ds_limit_in = 64'h10_8800;
        8: {wide_mode_in, wide_mode_attribute_in, fs_base_offset_in} = {2'b11, 64'h7fff_fff0_0000};
        9: thread_flags_in = 64'h1;
        10: enclave_init_in = 1'b0;
        11: wide_mode_attribute_in = 1'b1;
        12: os_fx_state_enable_in = 1'b0;
        13: enclave_feature_mask_in = 64'h7;
        14: {os_extended_state_enable_in, xcr0_in, enclave_feature_mask_in} = {1'b1, 64'h3, 64'h7};
        15: frame_count_in = FW'(1);
        16: entry_offset_in = 64'hfff0_0000;
        17: {flow_feature_in, flow_attr_nonzero_in} = 2'b11;
        default: {flow_feature_in, os_flow_guard_enable_in, shadow_stack_enable_in,
          flow_guard_save_offset_in} = {3'b111, 64'h6008};
      endcase
      run();
      chk("gp_fault", f, EESEQ_F_GP);
      chk("gp_no_entry", {enclave_mode_out, rcx_out}, 65'h0);
    end
  endtask
  task automatic t_pf(input logic [63:0] pg, input int kind);
    set_base();
    {flow_feature_in, os_flow_guard_enable_in, shadow_stack_enable_in} = 3'b111;
    {bad_page, bad_kind} = {pg, kind};
    run();
    chk("pf_fault", f, EESEQ_F_PF);
    chk("pf_addr", fault_addr_out, pg);
    chk("pf_no_entry", {enclave_mode_out, rcx_out}, 65'h0);
  endtask
  task automatic t_ok_legacy();
    set_base();
    run();
    chk("ok_fault", f, EESEQ_F_NONE);
    chk("ok_ctx", {enclave_mode_out, range_base_out, range_size_out}, {1'b1, 64'h10_0000, 64'h10_0000});
    chk("ok_thread", {thread_la_out ^ thread_pa_out, exit_ptr_out}, 128'h4000);
    chk("ok_xsave", xsave_pa_out, 64'h10_4000);
    chk("ok_gpr", {gpr_pa_out, rsp_save_addr_out}, {2{64'h10_5f48}});
    chk("ok_link", {rcx_out, rip_out, rax_out}, {64'h5123, 64'h10_0100, 64'h1});
    chk("ok_save_fs", {save_fs_sel_out, save_fs_base_out, save_fs_lim_out}, {16'h33, 64'ha000, 32'h1234});
    chk("ok_save_gs", {save_gs_sel_out, save_gs_ar_out, xcr0_out}, {16'h3b, 12'h0f2, 64'h7});
    chk("ok_new_fs", {fs_base_out, fs_lim_out}, {64'h10_8000, 32'hfff});
    chk("ok_new_gs", {gs_base_out, seg_sel_out}, {64'h10_9000, EESEQ_SEG_SEL});
    chk("ok_seg_ar", seg_ar_out, 14'b0001_1_11_1_0_0_1_1_1_0);
    chk("ok_debug", {tf_out, saved_tf_out, debug_suppress_out, pend_step_out}, 4'b0110);
  endtask
  task automatic t_ok_wide();
    set_base();
    {wide_mode_in, wide_mode_attribute_in, debug_opt_in_in, mtf_ctrl_in} = 4'hf;
    {os_extended_state_enable_in, flow_feature_in, os_flow_guard_enable_in} = 3'b111;
    shadow_stack_enable_in = 1'b1;
    run();
    chk("wide_fault", f, EESEQ_F_NONE);
    chk("wide_flow", flow_pa_out, 64'h10_6010);
    chk("wide_xcr0", {xcr0_out, save_xcr0_out}, {64'h3, 64'h7});
    chk("wide_pend", {pend_step_out, pend_mtf_out}, 2'b11);
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    set_base();
    {failures, check_count, start_in, rst_b_in} = '0;
    repeat (20) @(negedge core_clk_in);
    rst_b_in = 1'b1;
    t_gp_table();
    for (int k = 0; k < 9; k++) if (k < 6 || k == 8) t_pf(64'h10_1000, k);
    for (int k = 0; k < 10; k++) t_pf(64'h10_4000, k);
    t_pf(64'h10_5000, 6);
    t_pf(64'h10_6000, 5);
    t_ok_legacy();
    t_ok_wide();
    @(negedge core_clk_in);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge core_clk_in);
    failures++;
    final_report();
  end
endmodule
`default_nettype wire
